// file: common/serial_cfg_pkg.sv
// Package for the serial unit clock and channel 0 mode setup block.
// Assumes a single ref_clk domain and a plain strobe register port.
package serial_cfg_pkg;
    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    localparam int         DATA_W          = 16;
    localparam int         ADDR_W          = 3;
    localparam logic [2:0] OFF_PER         = 3'h0;
    localparam logic [2:0] OFF_SPS         = 3'h1;
    localparam logic [2:0] OFF_SMR         = 3'h2;
    localparam logic [2:0] OFF_DIV         = 3'h3;
    localparam logic [2:0] OFF_STATUS      = 3'h4;
    localparam logic [2:0] OFF_MASK        = 3'h5;
    localparam logic [2:0] OFF_CMD         = 3'h6;
    localparam logic [2:0] OFF_STATE       = 3'h7;
    // ----------------------------------------------------------------
    // Field layouts
    // ----------------------------------------------------------------
    localparam int         PER_W           = 8;
    localparam int         PER_UNIT_EN     = 2;
    localparam int         SPS_USED_W      = 8;
    localparam int         PRS_W           = 4;
    localparam int         PRS_A_LSB       = 0;
    localparam int         PRS_B_LSB       = 4;
    localparam int         PRE_W           = 15;
    localparam int         SMR_CKS         = 15;
    localparam int         SMR_CCS         = 14;
    localparam int         SMR_STS         = 8;
    localparam int         SMR_MD_HI       = 2;
    localparam int         SMR_MD_LO       = 1;
    localparam int         SMR_IRQ_SRC     = 0;
    localparam int         DIV_LSB         = 9;
    localparam int         DIV_W           = 7;
    localparam int         CMD_START       = 0;
    localparam int         IRQ_W           = 3;
    localparam int         IRQ_CHANNEL     = 0;
    localparam int         IRQ_START       = 1;
    localparam int         IRQ_MODE_ERR    = 2;
    // ----------------------------------------------------------------
    // Modes and reset values
    // ----------------------------------------------------------------
    localparam logic [1:0] MODE_CSI        = 2'h0;
    localparam logic [1:0] MODE_UART       = 2'h1;
    localparam logic [1:0] MODE_I2C        = 2'h2;
    localparam logic [1:0] MODE_BAD        = 2'h3;
    localparam logic [7:0] RST_PER         = 8'h00;
    localparam logic [7:0] RST_SPS         = 8'h00;
    localparam logic [15:0] RST_SMR        = 16'h0020;
    localparam logic [6:0] RST_DIV         = 7'h00;

    typedef enum logic [0:0] {
        CH_IDLE = 1'b0,
        CH_BUSY = 1'b1
    } channel_state_t;

    // Ones in the low f bits: a tick every 2^f cycles.
    function automatic logic [PRE_W-1:0] low_mask(input logic [PRS_W-1:0] f);
        logic [15:0] m;
        m = (16'h0001 << f) - 16'h0001;
        return m[PRE_W-1:0];
    endfunction
endpackage

// file: common/prescale_if.sv
// Interface between the channel setup logic and the prescaler.
// Assumes both ends run on the same ref_clk.
`timescale 1ns/1ps
interface prescale_if;
    logic       enable;
    logic [3:0] field_a;
    logic [3:0] field_b;
    logic       tick_a;
    logic       tick_b;
    modport provider (input enable, input field_a, input field_b,
                      output tick_a, output tick_b);
    modport consumer (output enable, output field_a, output field_b,
                      input tick_a, input tick_b);
endinterface

// file: core/clock_prescaler.sv
// Prescaler making two power-of-two tick streams from ref_clk.
// Assumes enable, field_a and field_b come from logic on ref_clk.
`timescale 1ns/1ps
module clock_prescaler
    import serial_cfg_pkg::*;
(
    // Clock and reset
    input wire logic          ref_clk,
    input wire logic          rst,
    // Tick port
    prescale_if.provider      pif
);
    typedef struct packed {
        logic [PRE_W-1:0] count;
    } pre_state_t;

    pre_state_t st;
    pre_state_t next_st;

    // ----------------------------------------------------------------
    // Divider chain
    // ----------------------------------------------------------------
    // The chain is held at zero while the unit clock is off, so a new
    // setting starts from a known phase.
    always_comb begin
        next_st = st;
        if (pif.enable) begin
            next_st.count = st.count + 15'h0001;
        end else begin
            next_st.count = '0;
        end
    end

    assign pif.tick_a = pif.enable &&
        ((st.count & low_mask(pif.field_a)) == low_mask(pif.field_a));
    assign pif.tick_b = pif.enable &&
        ((st.count & low_mask(pif.field_b)) == low_mask(pif.field_b));

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule // clock_prescaler

// file: core/serial_channel_clock_mode_setup.sv
// Serial unit clock gate, prescaler control and channel 0 mode setup.
// Assumes a same-clock register master and asynchronous sck and rxd pins.
`timescale 1ns/1ps
module serial_channel_clock_mode_setup
    import serial_cfg_pkg::*;
(
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // Register port
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    output wire logic [DATA_W-1:0] rd_data,
    // Pins
    input  wire logic              sck_in,
    input  wire logic              rxd_in,
    // Shift datapath events
    input  wire logic              transfer_done,
    input  wire logic              buffer_empty,
    // Clocking and mode outputs
    output wire logic              unit_clock_active,
    output wire logic              operation_tick,
    output wire logic              transfer_clock,
    output wire logic              transfer_edge,
    output wire logic              transfer_start,
    output wire logic              channel_busy,
    output wire logic [1:0]        protocol_mode,
    output wire logic              mode_csi,
    output wire logic              mode_uart,
    output wire logic              mode_i2c,
    output wire logic              start_on_rx_edge,
    // Interrupts
    output wire logic              channel_event,
    output wire logic              irq
);
    typedef struct packed {
        logic [PER_W-1:0]      per;
        logic [SPS_USED_W-1:0] sps;
        logic [DATA_W-1:0]     smr;
        logic [DIV_W-1:0]      div;
        logic [IRQ_W-1:0]      status;
        logic [IRQ_W-1:0]      mask;
        logic [DATA_W-1:0]     rd_data;
        logic                  sck_s1;
        logic                  sck_s2;
        logic                  sck_s3;
        logic                  sck_level;
        logic                  rxd_s1;
        logic                  rxd_s2;
        logic                  rxd_s3;
        logic                  rxd_level;
        logic [DIV_W-1:0]      half_cnt;
        logic                  transfer_clock;
        logic                  transfer_edge;
        logic                  op_tick;
        logic                  start;
        channel_state_t        ch_state;
        logic                  channel_event;
        logic                  irq;
        logic                  mode_csi;
        logic                  mode_uart;
        logic                  mode_i2c;
    } setup_state_t;

    setup_state_t st;
    setup_state_t next_st;
    prescale_if   pif ();

    logic             unit_on;
    logic             mck_tick;
    logic             rx_fall;
    logic             sw_start;
    logic             trigger;
    logic             ch_ev;
    logic             mode_err;
    logic [IRQ_W-1:0] events;

    // ----------------------------------------------------------------
    // Prescaler
    // ----------------------------------------------------------------
    assign pif.enable  = st.per[PER_UNIT_EN];
    assign pif.field_a = st.sps[PRS_A_LSB +: PRS_W];
    assign pif.field_b = st.sps[PRS_B_LSB +: PRS_W];

    clock_prescaler u_prescaler (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pif     (pif)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st  = st;
        unit_on  = st.per[PER_UNIT_EN];
        mck_tick = unit_on &&
            (st.smr[SMR_CKS] ? pif.tick_b : pif.tick_a);
        sw_start = wr_en && (addr == OFF_CMD) && wr_data[CMD_START];
        mode_err = wr_en && (addr == OFF_SMR) &&
            (wr_data[SMR_MD_HI:SMR_MD_LO] == MODE_BAD);
        next_st.op_tick = mck_tick;

        // Pin synchronisers: a change counts once stages two and three agree.
        next_st.sck_s1 = sck_in;
        next_st.sck_s2 = st.sck_s1;
        next_st.sck_s3 = st.sck_s2;
        if (st.sck_s2 == st.sck_s3) begin
            next_st.sck_level = st.sck_s3;
        end
        next_st.rxd_s1 = rxd_in;
        next_st.rxd_s2 = st.rxd_s1;
        next_st.rxd_s3 = st.rxd_s2;
        rx_fall = 1'b0;
        if (st.rxd_s2 == st.rxd_s3) begin
            next_st.rxd_level = st.rxd_s3;
            rx_fall = st.rxd_level && !st.rxd_s3;
        end

        // Transfer clock; it freezes while the unit clock is stopped.
        next_st.transfer_edge = 1'b0;
        if (!unit_on) begin
            next_st.half_cnt = '0;
        end else if (st.smr[SMR_CCS]) begin
            next_st.transfer_clock = st.sck_level;
            next_st.transfer_edge  = st.sck_level && !st.transfer_clock;
            next_st.half_cnt       = '0;
        end else if (mck_tick) begin
            if (st.half_cnt >= st.div) begin
                next_st.half_cnt       = '0;
                next_st.transfer_clock = !st.transfer_clock;
                next_st.transfer_edge  = !st.transfer_clock;
            end else begin
                next_st.half_cnt = st.half_cnt + 7'h01;
            end
        end

        // Start trigger and channel activity.
        trigger = unit_on && (st.ch_state == CH_IDLE) &&
            (st.smr[SMR_STS] ? rx_fall : sw_start);
        next_st.start = trigger;
        case (st.ch_state)
            CH_IDLE: begin
                if (trigger) begin
                    next_st.ch_state = CH_BUSY;
                end
            end
            CH_BUSY: begin
                if (transfer_done || !unit_on) begin
                    next_st.ch_state = CH_IDLE;
                end
            end
            default: begin
                next_st.ch_state = CH_IDLE;
            end
        endcase

        // Interrupt source and sticky status; a new event beats the read clear.
        ch_ev = unit_on &&
            (st.smr[SMR_IRQ_SRC] ? buffer_empty : transfer_done);
        next_st.channel_event = ch_ev;
        events = '0;
        events[IRQ_CHANNEL]  = ch_ev;
        events[IRQ_START]    = trigger;
        events[IRQ_MODE_ERR] = mode_err;
        if (rd_en && (addr == OFF_STATUS)) begin
            next_st.status = events;
        end else begin
            next_st.status = st.status | events;
        end

        // Register writes.
        if (wr_en) begin
            case (addr)
                OFF_PER:  next_st.per  = wr_data[PER_W-1:0];
                OFF_SPS:  next_st.sps  = wr_data[SPS_USED_W-1:0];
                OFF_SMR:  next_st.smr  = wr_data;
                OFF_DIV:  next_st.div  = wr_data[DIV_LSB +: DIV_W];
                OFF_MASK: next_st.mask = wr_data[IRQ_W-1:0];
                default:  next_st.per  = st.per;
            endcase
        end
        next_st.mode_csi  = next_st.smr[SMR_MD_HI:SMR_MD_LO] == MODE_CSI;
        next_st.mode_uart = next_st.smr[SMR_MD_HI:SMR_MD_LO] == MODE_UART;
        next_st.mode_i2c  = next_st.smr[SMR_MD_HI:SMR_MD_LO] == MODE_I2C;
        next_st.irq       = |(next_st.status & next_st.mask);

        // Register reads; the data stand one cycle after the strobe only.
        next_st.rd_data = '0;
        if (rd_en) begin
            case (addr)
                OFF_PER:    next_st.rd_data[PER_W-1:0]      = st.per;
                OFF_SPS:    next_st.rd_data[SPS_USED_W-1:0] = st.sps;
                OFF_SMR:    next_st.rd_data                 = st.smr;
                OFF_DIV:    next_st.rd_data[DIV_LSB +: DIV_W] = st.div;
                OFF_STATUS: next_st.rd_data[IRQ_W-1:0]      = st.status;
                OFF_MASK:   next_st.rd_data[IRQ_W-1:0]      = st.mask;
                OFF_STATE:  next_st.rd_data[2:0] = {st.sck_level, st.transfer_clock,
                                                    st.ch_state == CH_BUSY};
                default:    next_st.rd_data = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st          <= '0;
            st.per      <= RST_PER;
            st.sps      <= RST_SPS;
            st.smr      <= RST_SMR;
            st.div      <= RST_DIV;
            st.ch_state <= CH_IDLE;
            st.mode_csi <= 1'b1;
            st.sck_s1   <= 1'b1;
            st.sck_s2   <= 1'b1;
            st.sck_s3   <= 1'b1;
            st.sck_level <= 1'b1;
            st.rxd_s1   <= 1'b1;
            st.rxd_s2   <= 1'b1;
            st.rxd_s3   <= 1'b1;
            st.rxd_level <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign rd_data           = st.rd_data;
    assign unit_clock_active = st.per[PER_UNIT_EN];
    assign operation_tick    = st.op_tick;
    assign transfer_clock    = st.transfer_clock;
    assign transfer_edge     = st.transfer_edge;
    assign transfer_start    = st.start;
    assign channel_busy      = st.ch_state == CH_BUSY;
    assign protocol_mode     = st.smr[SMR_MD_HI:SMR_MD_LO];
    assign mode_csi          = st.mode_csi;
    assign mode_uart         = st.mode_uart;
    assign mode_i2c          = st.mode_i2c;
    assign start_on_rx_edge  = st.smr[SMR_STS];
    assign channel_event     = st.channel_event;
    assign irq               = st.irq;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    // Held over two cycles, since a write can switch the gate in between.
    property p_gate_stops;
        @(posedge ref_clk) disable iff (rst)
        (!unit_on && $past(!unit_on)) |->
            (!mck_tick && !pif.tick_a && $stable(st.transfer_clock));
    endproperty
    a_gate_stops: assert property (p_gate_stops)
        else $error("unit clock not stopped while gate is off");

    sequence s_fast_a;
        unit_on && (pif.field_a == 4'h0);
    endsequence
    property p_undivided;
        @(posedge ref_clk) disable iff (rst)
        s_fast_a [*2] |-> pif.tick_a && $past(pif.tick_a);
    endproperty
    a_undivided: assert property (p_undivided)
        else $error("undivided prescale does not tick every cycle");

    property p_div2;
        @(posedge ref_clk) disable iff (rst)
        (unit_on && pif.field_a == 4'h1 && pif.tick_a) |=>
            (!pif.tick_a || !unit_on || pif.field_a != 4'h1);
    endproperty
    a_div2: assert property (p_div2)
        else $error("divide by two ticks on consecutive cycles");

    property p_clock_pick;
        @(posedge ref_clk) disable iff (rst)
        unit_on |-> (mck_tick == (st.smr[SMR_CKS] ? pif.tick_b : pif.tick_a));
    endproperty
    a_clock_pick: assert property (p_clock_pick)
        else $error("operation clock taken from the wrong prescaler output");

    property p_pin_clock;
        @(posedge ref_clk) disable iff (rst)
        (unit_on && st.smr[SMR_CCS]) |=> (st.transfer_clock == $past(st.sck_level));
    endproperty
    a_pin_clock: assert property (p_pin_clock)
        else $error("transfer clock does not follow the sck pin");

    sequence s_rx_edge_only;
        rx_fall && !sw_start && !st.smr[SMR_STS];
    endsequence
    property p_sw_only;
        @(posedge ref_clk) disable iff (rst)
        s_rx_edge_only |=> !st.start;
    endproperty
    a_sw_only: assert property (p_sw_only)
        else $error("rxd edge started a transfer in software trigger mode");

    property p_rx_start;
        @(posedge ref_clk) disable iff (rst)
        (unit_on && st.smr[SMR_STS] && rx_fall && st.ch_state == CH_IDLE) |=>
            (st.start && st.ch_state == CH_BUSY);
    endproperty
    a_rx_start: assert property (p_rx_start)
        else $error("rxd falling edge did not start the transfer");

    property p_bad_mode;
        @(posedge ref_clk) disable iff (rst)
        mode_err |=> (st.status[IRQ_MODE_ERR] &&
            !(st.mode_csi || st.mode_uart || st.mode_i2c));
    endproperty
    a_bad_mode: assert property (p_bad_mode)
        else $error("illegal mode write not flagged");

    property p_irq_source;
        @(posedge ref_clk) disable iff (rst)
        (unit_on && transfer_done && !buffer_empty) |=>
            (st.channel_event == !$past(st.smr[SMR_IRQ_SRC]));
    endproperty
    a_irq_source: assert property (p_irq_source)
        else $error("channel event taken from the wrong source");

    property p_half_period;
        @(posedge ref_clk) disable iff (rst)
        (unit_on && !st.smr[SMR_CCS] && mck_tick && st.half_cnt == st.div) |=>
            (st.transfer_clock != $past(st.transfer_clock) && st.half_cnt == 7'h00);
    endproperty
    a_half_period: assert property (p_half_period)
        else $error("transfer clock did not toggle at divider count");

    property p_no_early_toggle;
        @(posedge ref_clk) disable iff (rst)
        (unit_on && !st.smr[SMR_CCS] && st.half_cnt < st.div) |=>
            $stable(st.transfer_clock);
    endproperty
    a_no_early_toggle: assert property (p_no_early_toggle)
        else $error("transfer clock toggled before divider count");
endmodule // serial_channel_clock_mode_setup

// file: testbench/serial_channel_clock_mode_setup_bench.sv
// Self-checking bench for the serial unit clock gate and channel 0 mode setup block.
// Assumes the design package and the prescaler interface are compiled before this file.
`timescale 1ns/1ps
module serial_channel_clock_mode_setup_bench
    import serial_cfg_pkg::*;
;
    // ----------------------------------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------------------------------
    logic              ref_clk = 1'b0;
    logic              rst = 1'b1;
    logic [ADDR_W-1:0] addr = 3'h0;
    logic [DATA_W-1:0] wr_data = 16'h0000;
    logic              wr_en = 1'b0;
    logic              rd_en = 1'b0;
    logic [DATA_W-1:0] rd_data;
    logic              sck_in = 1'b0;
    logic              rxd_in = 1'b1;
    logic              transfer_done = 1'b0;
    logic              buffer_empty = 1'b0;
    logic              unit_clock_active, operation_tick, transfer_clock, transfer_edge;
    logic              transfer_start, channel_busy, mode_csi, mode_uart, mode_i2c;
    logic              start_on_rx_edge, channel_event, irq;
    logic [1:0]        protocol_mode;
    int                failures = 0;
    int                compares = 0;
    int                n;

    serial_channel_clock_mode_setup uut (
        .ref_clk(ref_clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .sck_in(sck_in), .rxd_in(rxd_in),
        .transfer_done(transfer_done), .buffer_empty(buffer_empty),
        .unit_clock_active(unit_clock_active), .operation_tick(operation_tick),
        .transfer_clock(transfer_clock), .transfer_edge(transfer_edge),
        .transfer_start(transfer_start), .channel_busy(channel_busy),
        .protocol_mode(protocol_mode), .mode_csi(mode_csi), .mode_uart(mode_uart),
        .mode_i2c(mode_i2c), .start_on_rx_edge(start_on_rx_edge),
        .channel_event(channel_event), .irq(irq)
    );

    always #2.5 ref_clk = ~ref_clk;

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    // Samples land 1 ns after the edge so the design's updates are settled.
    task step;
        @(posedge ref_clk);
        #1;
    endtask

    task give_verdict;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task tmo;
        failures++;
        $display("CHECK FAILED bounded wait expected event seen none");
        give_verdict;
    endtask

    task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge ref_clk);
        wr_en   <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe, so they are sampled there.
    task rd(input logic [2:0] a, input logic [15:0] exp, input string nm);
        @(posedge ref_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1;
        chk(nm, exp, rd_data);
    endtask

    task pulse(input int which);
        @(posedge ref_clk);
        if (which == 0) transfer_done <= 1'b1;
        else buffer_empty <= 1'b1;
        @(posedge ref_clk);
        transfer_done <= 1'b0;
        buffer_empty  <= 1'b0;
        #1;
    endtask

    function automatic logic sig(input int sel);
        case (sel)
            0:       return operation_tick;
            1:       return transfer_edge;
            default: return transfer_start;
        endcase
    endfunction

    task wait_sig(input int sel);
        int i;
        for (i = 0; i < 300 && sig(sel) !== 1'b1; i++) step;
        if (i == 300) tmo;
    endtask

    // Cycles between two successive pulses of the chosen output.
    task gap(input int sel, output int cnt);
        wait_sig(sel);
        cnt = 0;
        do begin
            step;
            cnt++;
        end while (sig(sel) !== 1'b1 && cnt < 300);
        if (cnt == 300) tmo;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task t_reset_gate;
        rd(OFF_PER, 16'h0000, "enable reg");
        rd(OFF_SMR, 16'h0020, "mode reg");
        chk("mode_csi", 16'h0001, mode_csi);
        chk("unit off", 16'h0000, unit_clock_active);
        wr(OFF_PER, 16'h0004);
        chk("unit on", 16'h0001, unit_clock_active);
        $display("test reset_gate done");
    endtask

    task t_prescale;
        wr(OFF_SPS, 16'h0021);
        wr(OFF_SMR, 16'h0022);
        gap(0, n);
        chk("tick gap a", 16'h0002, n[15:0]);
        wr(OFF_SMR, 16'h8022);
        // One cycle lets a tick from the old selection drain before the count.
        step;
        gap(0, n);
        chk("tick gap b", 16'h0004, n[15:0]);
        $display("test prescale done");
    endtask

    task t_modes;
        for (int m = 0; m < 4; m++) begin
            wr(OFF_SMR, 16'h0020 | 16'(m << 1));
            chk("protocol_mode", 16'(m), protocol_mode);
            chk("mode flags", {13'h0000, m == 2, m == 1, m == 0},
                {13'h0000, mode_i2c, mode_uart, mode_csi});
        end
        rd(OFF_STATUS, 16'h0004, "illegal mode flag");
        $display("test modes done");
    endtask

    task t_divider;
        wr(OFF_SPS, 16'h0000);
        wr(OFF_SMR, 16'h0022);
        for (int d = 1; d < 3; d++) begin
            wr(OFF_DIV, 16'(d << 9));
            gap(1, n);
            chk("edge gap", 16'(2 * (d + 1)), n[15:0]);
        end
        wr(OFF_SMR, 16'h4022);
        @(posedge ref_clk) sck_in <= 1'b1;
        repeat (8) step;
        chk("pin clock high", 16'h0001, transfer_clock);
        @(posedge ref_clk) sck_in <= 1'b0;
        repeat (8) step;
        chk("pin clock low", 16'h0000, transfer_clock);
        $display("test divider done");
    endtask

    task t_start_irq;
        wr(OFF_MASK, 16'h0001);
        wr(OFF_SMR, 16'h0022);
        wr(OFF_CMD, 16'h0001);
        chk("sw start", 16'h0003, {transfer_start, channel_busy});
        pulse(0);
        chk("done event", 16'h0001, channel_event);
        repeat (2) step;
        chk("irq set", 16'h0001, irq);
        rd(OFF_STATUS, 16'h0003, "status");
        step;
        chk("irq cleared", 16'h0000, irq);
        wr(OFF_SMR, 16'h0023);
        pulse(0);
        chk("done ignored", 16'h0000, channel_event);
        pulse(1);
        chk("empty event", 16'h0001, channel_event);
        $display("test start_irq done");
    endtask

    task t_rx_start;
        @(posedge ref_clk) rxd_in <= 1'b0;
        repeat (8) step;
        chk("rx edge ignored", 16'h0000, channel_busy);
        @(posedge ref_clk) rxd_in <= 1'b1;
        repeat (8) step;
        wr(OFF_SMR, 16'h0122);
        chk("start_on_rx_edge", 16'h0001, start_on_rx_edge);
        wr(OFF_CMD, 16'h0001);
        chk("sw start ignored", 16'h0000, channel_busy);
        @(posedge ref_clk) rxd_in <= 1'b0;
        wait_sig(2);
        chk("rx edge start", 16'h0001, channel_busy);
        @(posedge ref_clk) rxd_in <= 1'b1;
        pulse(0);
        wr(OFF_PER, 16'h0000);
        n = 0;
        for (int k = 0; k < 40; k++) begin
            step;
            if (operation_tick !== 1'b0) n++;
        end
        chk("ticks while off", 16'h0000, n[15:0]);
        $display("test rx_start done");
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset_gate();
        t_prescale();
        t_modes();
        t_divider();
        t_start_irq();
        t_rx_start();
        give_verdict();
    end
endmodule // serial_channel_clock_mode_setup_bench
